// ==== design/alu_sub_xor_pkg.sv ====
/*
 * Shared definitions for the subtract, swap, skip, table read and XOR
 * execution slice: operation codes, sequencer states, status bit
 * positions, reset values and program memory page layout.
 * Assumes a 4096-word program memory split into 16 pages of 256 words.
 */
`default_nettype none

package alu_sub_xor_pkg;

    // =====================================================================
    // operations handled by this slice
    typedef enum logic [3:0] {
        SUB_MEM,
        SUB_TO_MEM,
        SUB_IMM,
        SWAP_MEM,
        SWAP_TO_WORK,
        SKIP_NIL,
        TAB_CUR,
        TAB_LAST,
        XOR_MEM,
        XOR_TO_MEM,
        XOR_IMM
    } op_t;

    // =====================================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_DUMMY
    } state_t;

    // =====================================================================
    // status bit positions and reset values
    localparam int FLAG_W = 4;
    localparam int FL_WRAP = 3;
    localparam int FL_NIL = 2;
    localparam int FL_HALF = 1;
    localparam int FL_BORROW = 0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'h00;

    // =====================================================================
    // program memory layout
    localparam int DATA_W = 8;
    localparam int PROG_W = 15;
    localparam int PAGE_W = 4;
    localparam int PADDR_W = 12;
    localparam logic [3:0] LAST_PAGE = 4'hf;

endpackage : alu_sub_xor_pkg

`default_nettype wire

// ==== design/alu_sub_xor.sv ====
/*
 * Execution slice for subtract, nibble exchange, skip when nil, table
 * fetch and exclusive-OR. Holds the work register, the four arithmetic
 * status bits and the lookup upper-byte register.
 * Assumes the core presents the addressed data byte on mem_rd_data_in in
 * the cycle an operation is offered, and that program memory drives the
 * word on prog_data_in while prog_rd_out is high.
 */
`default_nettype none

module alu_sub_xor (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic op_valid_in,
    input wire alu_sub_xor_pkg::op_t op_code_in,
    input wire logic [7:0] operand_in,
    input wire logic [7:0] mem_rd_data_in,
    input wire logic [7:0] lookup_pointer_in,
    input wire logic [3:0] page_in,
    input wire logic [14:0] prog_data_in,
    output logic op_ready_out,
    output logic mem_wr_en_out,
    output logic [7:0] mem_wr_data_out,
    output logic [11:0] prog_addr_out,
    output logic prog_rd_out,
    output logic discard_next_out,
    output logic [7:0] work_out,
    output logic [7:0] lookup_upper_byte_out,
    output logic signed_wrap_bit_out,
    output logic result_nil_flag_out,
    output logic half_borrow_bit_out,
    output logic borrow_out_bit_out
);

    // =====================================================================
    // reset release
    logic rst_s1_q;
    logic rst_ok_q;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_q <= 1'b0;
            rst_ok_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_ok_q <= rst_s1_q;
        end
    end

    // =====================================================================
    // arithmetic helpers
    // returns {borrow_bit, half_bit, wrap_bit, result}
    function automatic logic [10:0] sub8(input logic [7:0] a,
                                         input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] half;
        logic wrap;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        wrap = (a[7] != b[7]) && (full[7] != a[7]);
        return {full[8], half[4], wrap, full[7:0]};
    endfunction : sub8

    function automatic logic [3:0] sub_flags(input logic [10:0] s);
        logic [3:0] f;
        f = 4'h0;
        f[alu_sub_xor_pkg::FL_WRAP] = s[8];
        f[alu_sub_xor_pkg::FL_NIL] = (s[7:0] == 8'h00);
        f[alu_sub_xor_pkg::FL_HALF] = s[9];
        f[alu_sub_xor_pkg::FL_BORROW] = s[10];
        return f;
    endfunction : sub_flags

    // =====================================================================
    // state
    alu_sub_xor_pkg::state_t state_q, state_d;
    logic [7:0] work_q, work_d;
    logic [3:0] flags_q, flags_d;
    logic [7:0] upper_q, upper_d;
    logic mem_we_q, mem_we_d;
    logic [7:0] mem_wd_q, mem_wd_d;
    logic [11:0] paddr_q, paddr_d;
    logic prd_q, prd_d;
    logic discard_q, discard_d;

    logic take;
    logic [7:0] operand_b;
    logic [10:0] diff;
    logic [7:0] swapped;
    logic [7:0] xored;

    assign op_ready_out = rst_ok_q && (state_q == alu_sub_xor_pkg::ST_IDLE);
    assign take = op_valid_in && op_ready_out;
    assign operand_b = (op_code_in == alu_sub_xor_pkg::SUB_IMM ||
                        op_code_in == alu_sub_xor_pkg::XOR_IMM) ?
                       operand_in : mem_rd_data_in;
    assign diff = sub8(work_q, operand_b);
    assign swapped = {mem_rd_data_in[3:0], mem_rd_data_in[7:4]};
    assign xored = work_q ^ operand_b;

    always_comb begin
        state_d = state_q;
        work_d = work_q;
        flags_d = flags_q;
        upper_d = upper_q;
        mem_we_d = 1'b0;
        mem_wd_d = mem_wd_q;
        paddr_d = paddr_q;
        prd_d = 1'b0;
        discard_d = 1'b0;
        unique case (state_q)
            alu_sub_xor_pkg::ST_IDLE: begin
                if (take) begin
                    unique case (op_code_in)
                        alu_sub_xor_pkg::SUB_MEM,
                        alu_sub_xor_pkg::SUB_IMM: begin
                            work_d = diff[7:0];
                            flags_d = sub_flags(diff);
                        end
                        alu_sub_xor_pkg::SUB_TO_MEM: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = diff[7:0];
                            flags_d = sub_flags(diff);
                        end
                        alu_sub_xor_pkg::SWAP_MEM: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = swapped;
                        end
                        alu_sub_xor_pkg::SWAP_TO_WORK: begin
                            work_d = swapped;
                        end
                        alu_sub_xor_pkg::SKIP_NIL: begin
                            if (mem_rd_data_in == 8'h00) begin
                                discard_d = 1'b1;
                                state_d = alu_sub_xor_pkg::ST_DUMMY;
                            end
                        end
                        alu_sub_xor_pkg::TAB_CUR: begin
                            paddr_d = {page_in, lookup_pointer_in};
                            prd_d = 1'b1;
                            state_d = alu_sub_xor_pkg::ST_FETCH;
                        end
                        alu_sub_xor_pkg::TAB_LAST: begin
                            paddr_d = {alu_sub_xor_pkg::LAST_PAGE,
                                       lookup_pointer_in};
                            prd_d = 1'b1;
                            state_d = alu_sub_xor_pkg::ST_FETCH;
                        end
                        alu_sub_xor_pkg::XOR_MEM,
                        alu_sub_xor_pkg::XOR_IMM: begin
                            work_d = xored;
                            flags_d[alu_sub_xor_pkg::FL_NIL] =
                                (xored == 8'h00);
                        end
                        alu_sub_xor_pkg::XOR_TO_MEM: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = xored;
                            flags_d[alu_sub_xor_pkg::FL_NIL] =
                                (xored == 8'h00);
                        end
                        default: begin
                        end
                    endcase
                end
            end
            alu_sub_xor_pkg::ST_FETCH: begin
                mem_we_d = 1'b1;
                mem_wd_d = prog_data_in[7:0];
                upper_d = {1'b0, prog_data_in[14:8]};
                state_d = alu_sub_xor_pkg::ST_IDLE;
            end
            alu_sub_xor_pkg::ST_DUMMY: begin
                state_d = alu_sub_xor_pkg::ST_IDLE;
            end
            default: begin
                state_d = alu_sub_xor_pkg::ST_IDLE;
            end
        endcase
    end

    // state leaves reset on the released copy, all on one edge
    always_ff @(posedge ref_clk_in or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            state_q <= alu_sub_xor_pkg::ST_IDLE;
            work_q <= alu_sub_xor_pkg::WORK_RST;
            flags_q <= alu_sub_xor_pkg::FLAGS_RST;
            upper_q <= alu_sub_xor_pkg::UPPER_RST;
            mem_we_q <= 1'b0;
            mem_wd_q <= 8'h00;
            paddr_q <= 12'h000;
            prd_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            state_q <= state_d;
            work_q <= work_d;
            flags_q <= flags_d;
            upper_q <= upper_d;
            mem_we_q <= mem_we_d;
            mem_wd_q <= mem_wd_d;
            paddr_q <= paddr_d;
            prd_q <= prd_d;
            discard_q <= discard_d;
        end
    end

    assign mem_wr_en_out = mem_we_q;
    assign mem_wr_data_out = mem_wd_q;
    assign prog_addr_out = paddr_q;
    assign prog_rd_out = prd_q;
    assign discard_next_out = discard_q;
    assign work_out = work_q;
    assign lookup_upper_byte_out = upper_q;
    assign signed_wrap_bit_out = flags_q[alu_sub_xor_pkg::FL_WRAP];
    assign result_nil_flag_out = flags_q[alu_sub_xor_pkg::FL_NIL];
    assign half_borrow_bit_out = flags_q[alu_sub_xor_pkg::FL_HALF];
    assign borrow_out_bit_out = flags_q[alu_sub_xor_pkg::FL_BORROW];

    // =====================================================================
    // checks
    sub_work_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SUB_MEM |=>
        work_q == 8'($past(work_q) - $past(mem_rd_data_in)) && !mem_we_q)
        else $error("memory subtract result wrong");

    sub_mem_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SUB_TO_MEM |=>
        mem_we_q && $stable(work_q) &&
        mem_wd_q == 8'($past(work_q) - $past(mem_rd_data_in)))
        else $error("memory destination subtract wrong");

    sub_borrow_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SUB_IMM |=>
        borrow_out_bit_out == ($past(work_q) >= $past(operand_in)) &&
        result_nil_flag_out == ($past(work_q) == $past(operand_in)))
        else $error("immediate subtract flags wrong");

    swap_mem_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SWAP_MEM |=>
        mem_we_q && $stable(flags_q) && $stable(work_q) &&
        mem_wd_q == {$past(mem_rd_data_in[3:0]), $past(mem_rd_data_in[7:4])})
        else $error("nibble swap to memory wrong");

    skip_nil_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SKIP_NIL &&
        mem_rd_data_in == 8'h00 |=>
        discard_next_out && !op_ready_out ##1
        op_ready_out && !discard_next_out)
        else $error("skip did not take two cycles");

    skip_pass_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::SKIP_NIL &&
        mem_rd_data_in != 8'h00 |=>
        !discard_next_out && op_ready_out && $stable(flags_q))
        else $error("skip taken on nonzero byte");

    tab_last_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::TAB_LAST |=>
        prog_rd_out && prog_addr_out[11:8] == alu_sub_xor_pkg::LAST_PAGE &&
        prog_addr_out[7:0] == $past(lookup_pointer_in))
        else $error("last page fetch address wrong");

    tab_data_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        state_q == alu_sub_xor_pkg::ST_FETCH |=>
        mem_we_q && mem_wd_q == $past(prog_data_in[7:0]) &&
        lookup_upper_byte_out == {1'b0, $past(prog_data_in[14:8])} &&
        $stable(flags_q))
        else $error("table fetch data placement wrong");

    xor_flag_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_ok_q)
        take && op_code_in == alu_sub_xor_pkg::XOR_IMM |=>
        work_q == ($past(work_q) ^ $past(operand_in)) &&
        result_nil_flag_out == ($past(work_q) == $past(operand_in)) &&
        borrow_out_bit_out == $past(borrow_out_bit_out) &&
        signed_wrap_bit_out == $past(signed_wrap_bit_out))
        else $error("xor result or flags wrong");

endmodule : alu_sub_xor

`default_nettype wire

// ==== dv/tb_alu_sub_xor.sv ====
/*
 * Self-checking bench for the subtract, swap, skip, table fetch and XOR
 * slice.
 * Assumes alu_sub_xor_pkg and alu_sub_xor are compiled first.
 */
`default_nettype none

module tb_alu_sub_xor;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // signals
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic op_valid_in = 1'b0;
    alu_sub_xor_pkg::op_t op_code_in = alu_sub_xor_pkg::SUB_MEM;
    logic [7:0] operand_in = 8'h00;
    logic [7:0] mem_rd_data_in = 8'h00;
    logic [7:0] lookup_pointer_in = 8'h00;
    logic [3:0] page_in = 4'h0;
    logic [14:0] prog_data_in = 15'h0000;
    logic op_ready_out, mem_wr_en_out, prog_rd_out, discard_next_out;
    logic [7:0] mem_wr_data_out, work_out, lookup_upper_byte_out;
    logic [11:0] prog_addr_out;
    logic wrap_w, nil_w, half_w, borrow_w;
    logic [7:0] work_m = 8'h00;
    logic [3:0] flags_m = 4'h0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    alu_sub_xor dut_u (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .op_valid_in(op_valid_in), .op_code_in(op_code_in),
        .operand_in(operand_in), .mem_rd_data_in(mem_rd_data_in),
        .lookup_pointer_in(lookup_pointer_in), .page_in(page_in),
        .prog_data_in(prog_data_in), .op_ready_out(op_ready_out),
        .mem_wr_en_out(mem_wr_en_out), .mem_wr_data_out(mem_wr_data_out),
        .prog_addr_out(prog_addr_out), .prog_rd_out(prog_rd_out),
        .discard_next_out(discard_next_out), .work_out(work_out),
        .lookup_upper_byte_out(lookup_upper_byte_out),
        .signed_wrap_bit_out(wrap_w), .result_nil_flag_out(nil_w),
        .half_borrow_bit_out(half_w), .borrow_out_bit_out(borrow_w)
    );

    // ==================================================================
    // helpers
    task automatic complete_run();
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // offers one request; returns 1 ns after the edge that takes it
    task automatic issue(input alu_sub_xor_pkg::op_t op,
                         input logic [7:0] imm, input logic [7:0] mem);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        #1;
        while (op_ready_out !== 1'b1 && n < 10) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        op_code_in = op;
        operand_in = imm;
        mem_rd_data_in = mem;
        op_valid_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        op_valid_in = 1'b0;
        mem_rd_data_in = ~mem;
        operand_in = ~imm;
    endtask : issue

    // one-cycle operation against a reference of work register and flags
    task automatic do_op(input alu_sub_xor_pkg::op_t op,
                         input logic [7:0] imm, input logic [7:0] mem);
        logic [8:0] sum;
        logic [4:0] hs;
        logic [7:0] b, res;
        logic wr;
        b = (op == alu_sub_xor_pkg::SUB_IMM ||
             op == alu_sub_xor_pkg::XOR_IMM) ? imm : mem;
        wr = op inside {alu_sub_xor_pkg::SUB_TO_MEM,
                        alu_sub_xor_pkg::SWAP_MEM,
                        alu_sub_xor_pkg::XOR_TO_MEM};
        res = {mem[3:0], mem[7:4]};
        if (op inside {alu_sub_xor_pkg::SUB_MEM, alu_sub_xor_pkg::SUB_IMM,
                       alu_sub_xor_pkg::SUB_TO_MEM}) begin
            sum = {1'b0, work_m} + {1'b0, ~b} + 9'h001;
            hs = {1'b0, work_m[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
            res = sum[7:0];
            flags_m = {(work_m[7] != b[7]) && (res[7] != work_m[7]),
                       res == 8'h00, hs[4], sum[8]};
        end else if (op inside {alu_sub_xor_pkg::XOR_MEM,
                     alu_sub_xor_pkg::XOR_IMM,
                     alu_sub_xor_pkg::XOR_TO_MEM}) begin
            res = work_m ^ b;
            flags_m[alu_sub_xor_pkg::FL_NIL] = (res == 8'h00);
        end
        issue(op, imm, mem);
        if (!wr) begin
            work_m = res;
        end
        chk("work", 16'(work_m), 16'(work_out));
        chk("flags", 16'(flags_m),
            16'({wrap_w, nil_w, half_w, borrow_w}));
        chk("mem write", 16'(wr), 16'(mem_wr_en_out));
        if (wr) begin
            chk("mem data", 16'(res), 16'(mem_wr_data_out));
        end
    endtask : do_op

    // ==================================================================
    // scenarios
    task automatic reset_values();
        chk("ready", 16'h0, 16'(op_ready_out));
        chk("work", 16'h0, 16'(work_out));
        chk("flags", 16'h0, 16'({wrap_w, nil_w, half_w, borrow_w}));
    endtask : reset_values

    task automatic subtract_forms();
        do_op(alu_sub_xor_pkg::SWAP_TO_WORK, 8'h00, 8'h3c);
        do_op(alu_sub_xor_pkg::SUB_MEM, 8'h00, 8'h44);
        do_op(alu_sub_xor_pkg::SUB_MEM, 8'h00, 8'h7f);
        do_op(alu_sub_xor_pkg::SUB_IMM, 8'h01, 8'h00);
        do_op(alu_sub_xor_pkg::SUB_TO_MEM, 8'h00, 8'h7f);
        do_op(alu_sub_xor_pkg::SUB_IMM, 8'h0f, 8'hff);
    endtask : subtract_forms

    task automatic xor_swap_forms();
        do_op(alu_sub_xor_pkg::XOR_MEM, 8'h00, work_m);
        do_op(alu_sub_xor_pkg::XOR_IMM, 8'h5a, 8'h00);
        do_op(alu_sub_xor_pkg::XOR_TO_MEM, 8'h00, 8'h5a);
        do_op(alu_sub_xor_pkg::SWAP_MEM, 8'h00, 8'h12);
    endtask : xor_swap_forms

    task automatic skip_cases();
        issue(alu_sub_xor_pkg::SKIP_NIL, 8'h00, 8'h00);
        chk("discard", 16'h1, 16'(discard_next_out));
        chk("ready", 16'h0, 16'(op_ready_out));
        @(posedge ref_clk_in);
        #1;
        chk("discard", 16'h0, 16'(discard_next_out));
        chk("ready", 16'h1, 16'(op_ready_out));
        issue(alu_sub_xor_pkg::SKIP_NIL, 8'h00, 8'h05);
        chk("discard", 16'h0, 16'(discard_next_out));
        chk("ready", 16'h1, 16'(op_ready_out));
        chk("flags", 16'(flags_m),
            16'({wrap_w, nil_w, half_w, borrow_w}));
    endtask : skip_cases

    task automatic table_fetch(input alu_sub_xor_pkg::op_t op,
                               input logic [3:0] pg, input logic [14:0] w);
        page_in = 4'h3;
        lookup_pointer_in = 8'ha5;
        issue(op, 8'h00, 8'h00);
        chk("prog read", 16'h1, 16'(prog_rd_out));
        chk("prog addr", 16'({pg, 8'ha5}), 16'(prog_addr_out));
        prog_data_in = w;
        @(posedge ref_clk_in);
        #1;
        prog_data_in = ~w;
        chk("mem write", 16'h1, 16'(mem_wr_en_out));
        chk("mem data", 16'(w[7:0]), 16'(mem_wr_data_out));
        chk("upper", 16'({1'b0, w[14:8]}),
            16'(lookup_upper_byte_out));
        chk("flags", 16'(flags_m),
            16'({wrap_w, nil_w, half_w, borrow_w}));
    endtask : table_fetch

    // ==================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk_in);
        #1;
        reset_values();
        rst_b_in = 1'b1;
        subtract_forms();
        xor_swap_forms();
        skip_cases();
        table_fetch(alu_sub_xor_pkg::TAB_CUR, 4'h3, 15'h5a3c);
        table_fetch(alu_sub_xor_pkg::TAB_LAST, alu_sub_xor_pkg::LAST_PAGE,
                    15'h25c3);
        complete_run();
    end

endmodule : tb_alu_sub_xor

`default_nettype wire
